// File: logic/vpc_ctrl.v
// key, one-wire and three-wire command front end with its command fifo
// Notes on behaviour
// - play/stop key toggles play and stop
// - next key stops at the last segment
// - previous key stops at segment zero
// - wrapping next key returns to segment zero
// - pause key suspends, resumes, busy stays set
// - stop key halts play, ignored when idle
// - one-wire data on pin 3, others keys
// - bytes e0..e7 set eight volume levels
// - f2 loops current segment, fe stops
// - bytes 00..db start that segment directly
// - bit high:low 1:3 zero, 3:1 one, lsb first
// - busy answers within 35 ms, one-wire
// - no sleep while one-wire mode selected
// - three-wire mode ignores every key
// - three-wire pins: 1 data, 2 select, 3 clock
// - data sampled on rising clock, lsb first
// - busy answers within 35 ms, three-wire
// - keys debounced about 10 ms
`timescale 1ns/10ps
`include "vpc_map.vh"

module vpc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_srst,
    // fill side
    input  wire             i_valid,
    output wire             o_ready,
    input  wire [WIDTH-1:0] i_data,
    // drain side
    output wire             o_valid,
    input  wire             i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign o_ready = (count != DEPTH[AW:0]);
    assign o_valid = (count != {(AW+1){1'b0}});
    assign o_data  = mem[rd_ptr];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_data;
                wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

module vpc_ctrl #(
    parameter TICK_CYC = `VPC_CLK_HZ / 1000000 * `VPC_TICK_US,
    parameter DEB_TK   = `VPC_DEBOUNCE_US / `VPC_TICK_US,
    parameter ST_TK    = `VPC_OW_START_MIN_US / `VPC_TICK_US,
    parameter BIT_TK   = `VPC_OW_BIT_MAX_US / `VPC_TICK_US,
    parameter FIFO_D   = 4
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // port pins, asynchronous
    input  wire [4:0]  i_port_pin,
    // configuration
    input  wire [1:0]  i_iface_mode,
    input  wire [14:0] i_key_mode,
    input  wire [7:0]  i_seg_last,
    // player side
    input  wire        i_player_ready,
    input  wire        i_seg_done,
    output reg         o_play_start,
    output reg  [7:0]  o_play_seg,
    output reg         o_stop,
    output reg         o_paused,
    output reg         o_loop,
    output reg  [2:0]  o_volume,
    // status
    output reg         o_busy,
    output reg         o_sleep_ok
);
    localparam OW_IDLE  = 4'b0001;
    localparam OW_START = 4'b0010;
    localparam OW_HIGH  = 4'b0100;
    localparam OW_LOW   = 4'b1000;

    reg  [4:0]  pin_meta;
    reg  [4:0]  pin_s;
    reg  [4:0]  pin_d;
    reg  [15:0] tick_cnt;
    reg         tick;
    wire        key_if  = (i_iface_mode != `VPC_IF_THREEWIRE);
    wire        ow_if   = (i_iface_mode == `VPC_IF_ONEWIRE);
    wire        tw_if   = (i_iface_mode == `VPC_IF_THREEWIRE);

    always @(posedge i_clk) begin
        if (i_srst) begin
            pin_meta <= 5'h1f;
            pin_s    <= 5'h1f;
            pin_d    <= 5'h1f;
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else begin
            pin_meta <= i_port_pin;
            pin_s    <= pin_meta;
            pin_d    <= pin_s;
            tick     <= (tick_cnt == TICK_CYC[15:0] - 16'h0001);
            tick_cnt <= (tick_cnt == TICK_CYC[15:0] - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end

    // key debounce and falling edge, one private driver per pin
    wire [4:0] key_trig;
    reg  [4:0] key_pend;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_key
            reg [10:0] deb;
            reg        lvl;
            reg        trig;
            assign key_trig[g] = trig;
            always @(posedge i_clk) begin
                if (i_srst) begin
                    deb  <= 11'h000;
                    lvl  <= 1'b1;
                    trig <= 1'b0;
                end else begin
                    trig <= 1'b0;
                    if (pin_s[g] == lvl)
                        deb <= 11'h000;
                    else if (tick) begin
                        if (deb == DEB_TK[10:0] - 11'h001) begin
                            deb  <= 11'h000;
                            lvl  <= pin_s[g];
                            trig <= !pin_s[g];
                        end else
                            deb <= deb + 11'h001;
                    end
                end
            end
        end
    endgenerate

    // one-wire receiver on pin 3
    reg [3:0]  ow_st;
    reg [9:0]  ow_cnt;
    reg [9:0]  ow_hi;
    reg [7:0]  ow_sh;
    reg [3:0]  ow_bits;
    reg        ow_done;
    wire       ow_fall = pin_d[3] && !pin_s[3];
    wire       ow_rise = !pin_d[3] && pin_s[3];
    wire       ow_bit  = (ow_hi > ow_cnt);

    always @(posedge i_clk) begin
        if (i_srst || !ow_if) begin
            ow_st   <= OW_IDLE;
            ow_cnt  <= 10'h000;
            ow_hi   <= 10'h000;
            ow_sh   <= 8'h00;
            ow_bits <= 4'h0;
            ow_done <= 1'b0;
        end else begin
            ow_done <= 1'b0;
            if (tick && ow_cnt != 10'h3ff)
                ow_cnt <= ow_cnt + 10'h001;
            case (ow_st)
                OW_IDLE: begin
                    ow_cnt <= 10'h000;
                    if (ow_fall)
                        ow_st <= OW_START;
                end
                OW_START: begin
                    if (ow_rise) begin
                        ow_cnt  <= 10'h000;
                        ow_bits <= 4'h0;
                        ow_st   <= (ow_cnt >= ST_TK[9:0]) ? OW_HIGH : OW_IDLE;
                    end
                end
                OW_HIGH: begin
                    if (ow_fall) begin
                        ow_hi  <= ow_cnt;
                        ow_cnt <= 10'h000;
                        ow_st  <= OW_LOW;
                    end else if (ow_cnt > BIT_TK[9:0])
                        ow_st <= OW_IDLE;
                end
                OW_LOW: begin
                    if (ow_rise) begin
                        ow_sh   <= {ow_bit, ow_sh[7:1]};
                        ow_bits <= ow_bits + 4'h1;
                        ow_cnt  <= 10'h000;
                        if (ow_bits == 4'h7) begin
                            ow_done <= 1'b1;
                            ow_st   <= OW_IDLE;
                        end else
                            ow_st <= OW_HIGH;
                    end else if (ow_cnt > BIT_TK[9:0])
                        ow_st <= OW_IDLE;
                end
                default: ow_st <= OW_IDLE;
            endcase
        end
    end

    // three-wire receiver: pin 1 data, pin 2 select, pin 3 clock
    reg [7:0] tw_sh;
    reg [3:0] tw_bits;
    reg       tw_done;
    always @(posedge i_clk) begin
        if (i_srst || !tw_if) begin
            tw_sh   <= 8'h00;
            tw_bits <= 4'h0;
            tw_done <= 1'b0;
        end else begin
            tw_done <= 1'b0;
            if (pin_s[2])
                tw_bits <= 4'h0;
            else if (!pin_d[3] && pin_s[3]) begin
                tw_sh <= {pin_s[1], tw_sh[7:1]};
                if (tw_bits == 4'h7) begin
                    tw_bits <= 4'h0;
                    tw_done <= 1'b1;
                end else
                    tw_bits <= tw_bits + 4'h1;
            end
        end
    end

    // byte holding stage in front of the fifo
    reg        rx_valid;
    reg  [7:0] rx_byte;
    wire       rx_ready;
    wire       cmd_valid;
    wire [7:0] cmd_byte;
    wire       cmd_take = cmd_valid && i_player_ready;

    always @(posedge i_clk) begin
        if (i_srst) begin
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else if (ow_done || tw_done) begin
            rx_valid <= 1'b1;
            rx_byte  <= ow_done ? ow_sh : tw_sh;
        end else if (rx_ready)
            rx_valid <= 1'b0;
    end

    vpc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_D),
        .AW    (2)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_valid (rx_valid),
        .o_ready (rx_ready),
        .i_data  (rx_byte),
        .o_valid (cmd_valid),
        .i_ready (cmd_take),
        .o_data  (cmd_byte)
    );

    // key selection, lowest pin first; pin 3 is data in one-wire mode
    reg  [2:0] ksel;
    reg  [4:0] kclr;
    reg        khit;
    integer    k;
    always @* begin
        ksel = `VPC_KM_OFF;
        kclr = 5'h00;
        khit = 1'b0;
        for (k = 4; k >= 0; k = k - 1) begin
            if (key_pend[k]) begin
                ksel = i_key_mode[k*3 +: 3];
                kclr = 5'h01 << k;
                khit = 1'b1;
            end
        end
    end

    wire [4:0] key_use = key_trig & {1'b1, !ow_if, 3'b111} & {5{key_if}};
    wire       key_go  = khit && !cmd_valid && i_player_ready;
    wire [7:0] seg_nx  = o_play_seg + 8'h01;
    wire [7:0] seg_pv  = o_play_seg - 8'h01;

    always @(posedge i_clk) begin
        if (i_srst) begin
            key_pend     <= 5'h00;
            o_play_start <= 1'b0;
            o_play_seg   <= 8'h00;
            o_stop       <= 1'b0;
            o_paused     <= 1'b0;
            o_loop       <= 1'b0;
            o_volume     <= `VPC_VOL_RESET;
            o_busy       <= 1'b0;
            o_sleep_ok   <= 1'b0;
        end else begin
            o_play_start <= 1'b0;
            o_stop       <= 1'b0;
            o_sleep_ok   <= !o_busy && !ow_if;
            key_pend     <= (key_pend & ~(key_go ? kclr : 5'h00)) | key_use;
            if (i_seg_done && o_busy) begin
                if (o_loop)
                    o_play_start <= 1'b1;
                else
                    o_busy <= 1'b0;
            end
            if (cmd_take) begin
                if (cmd_byte <= `VPC_SEG_MAX) begin
                    o_play_seg   <= cmd_byte;
                    o_play_start <= 1'b1;
                    o_busy       <= 1'b1;
                    o_paused     <= 1'b0;
                    o_loop       <= 1'b0;
                end else if (cmd_byte >= `VPC_VOL_LO && cmd_byte <= `VPC_VOL_HI)
                    o_volume <= cmd_byte[2:0];
                else if (cmd_byte == `VPC_CMD_LOOP)
                    o_loop <= 1'b1;
                else if (cmd_byte == `VPC_CMD_STOP) begin
                    o_play_start <= 1'b0;
                    o_stop   <= 1'b1;
                    o_busy   <= 1'b0;
                    o_paused <= 1'b0;
                    o_loop   <= 1'b0;
                end
            end else if (key_go) begin                                      // bytes above fall through
                case (ksel)
                    `VPC_KM_PLAYSTOP: begin
                        o_play_start <= !o_busy;
                        o_stop       <= o_busy;
                        o_busy       <= !o_busy;
                        o_paused     <= 1'b0;
                    end
                    `VPC_KM_NEXT, `VPC_KM_NEXT_WRAP: begin
                        if (o_play_seg < i_seg_last)
                            o_play_seg <= seg_nx;
                        else if (ksel == `VPC_KM_NEXT_WRAP)
                            o_play_seg <= 8'h00;
                        o_play_start <= 1'b1;
                        o_busy       <= 1'b1;
                        o_paused     <= 1'b0;
                    end
                    `VPC_KM_PREV, `VPC_KM_PREV_WRAP: begin
                        if (o_play_seg != 8'h00)
                            o_play_seg <= seg_pv;
                        else if (ksel == `VPC_KM_PREV_WRAP)
                            o_play_seg <= i_seg_last;
                        o_play_start <= 1'b1;
                        o_busy       <= 1'b1;
                        o_paused     <= 1'b0;
                    end
                    `VPC_KM_PAUSE: begin
                        if (o_busy)
                            o_paused <= !o_paused;
                    end
                    `VPC_KM_STOP: begin
                        if (o_busy) begin
                            o_play_start <= 1'b0;
                            o_stop   <= 1'b1;
                            o_busy   <= 1'b0;
                            o_paused <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// File: logic/vpc_map.vh
// constants for the voice playback control ports
`ifndef VPC_MAP_VH
`define VPC_MAP_VH

`define VPC_CLK_HZ          25000000
`define VPC_TICK_US         10
`define VPC_DEBOUNCE_US     10000
`define VPC_OW_START_US     5000
`define VPC_OW_START_MIN_US 4000
`define VPC_OW_BIT_MAX_US   2000

`define VPC_IF_KEY          2'h0
`define VPC_IF_ONEWIRE      2'h1
`define VPC_IF_THREEWIRE    2'h2

`define VPC_KM_OFF          3'h0
`define VPC_KM_PLAYSTOP     3'h1
`define VPC_KM_NEXT         3'h2
`define VPC_KM_PREV         3'h3
`define VPC_KM_NEXT_WRAP    3'h4
`define VPC_KM_PREV_WRAP    3'h5
`define VPC_KM_PAUSE        3'h6
`define VPC_KM_STOP         3'h7

`define VPC_SEG_MAX         8'hdb
`define VPC_VOL_LO          8'he0
`define VPC_VOL_HI          8'he7
`define VPC_CMD_LOOP        8'hf2
`define VPC_CMD_STOP        8'hfe
`define VPC_VOL_RESET       3'h7

`endif

// File: testbench/vpc_ctrl_chk.sv
// port assertions for the voice playback control block
`timescale 1ns/10ps
module vpc_ctrl_chk (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_srst,
    // configuration and player
    input wire logic [1:0] i_iface_mode,
    input wire logic       i_seg_done,
    // actions and status
    input wire logic       o_play_start,
    input wire logic [7:0] o_play_seg,
    input wire logic       o_stop,
    input wire logic       o_paused,
    input wire logic       o_loop,
    input wire logic [2:0] o_volume,
    input wire logic       o_busy,
    input wire logic       o_sleep_ok
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_reset_state: assert property (disable iff (1'b0) i_srst |=>
        o_volume == 3'h7 && !o_busy && !o_paused && !o_loop) else $error("reset state wrong");
    chk_start_busy: assert property (o_play_start |-> o_busy)
        else $error("start without busy");
    chk_stop_idle: assert property (o_stop |-> !o_busy && !o_paused)
        else $error("stop left busy");
    chk_no_sleep: assert property (i_iface_mode == 2'h1 |=> !o_sleep_ok)
        else $error("sleep allowed in one-wire mode");
    chk_pause_busy: assert property (o_paused |-> o_busy)
        else $error("paused without busy");
    chk_seg_range: assert property (o_play_start |-> o_play_seg <= 8'hdb)
        else $error("segment out of range");
    chk_vol_alone: assert property ($changed(o_volume) |-> !o_play_start && !o_stop)
        else $error("volume changed with playback action");
    chk_done_idle: assert property (i_seg_done && o_busy && !o_loop |=>
        !o_busy || o_play_start) else $error("busy after segment end");
    chk_loop_again: assert property (i_seg_done && o_busy && o_loop |->
        ##[1:3] o_play_start) else $error("loop did not restart");
endmodule

bind vpc_ctrl vpc_ctrl_chk chk_u (
    .i_clk(i_clk), .i_srst(i_srst), .i_iface_mode(i_iface_mode), .i_seg_done(i_seg_done),
    .o_play_start(o_play_start), .o_play_seg(o_play_seg), .o_stop(o_stop),
    .o_paused(o_paused), .o_loop(o_loop), .o_volume(o_volume), .o_busy(o_busy),
    .o_sleep_ok(o_sleep_ok)
);

// File: testbench/vpc_host.sv
// host model driving keys and serial lines on the port pins
`timescale 1ns/10ps
module vpc_host (
    // port pins, idle high
    output logic [4:0] o_pin
);
    localparam int TK = 80;

    initial o_pin = 5'h1f;

    task automatic ow_byte(input logic [7:0] b);
        o_pin[3] = 1'b0;
        #(50 * TK);
        for (int i = 0; i < 8; i++) begin
            o_pin[3] = 1'b1;
            #((b[i] ? 6 : 2) * TK);
            o_pin[3] = 1'b0;
            #((b[i] ? 2 : 6) * TK);
        end
        o_pin[3] = 1'b1;
    endtask

    task automatic tw_byte(input logic [7:0] b);
        o_pin[2] = 1'b0;
        #(60 * TK);
        for (int i = 0; i < 8; i++) begin
            o_pin[1] = b[i];
            o_pin[3] = 1'b0;
            #160;
            o_pin[3] = 1'b1;
            #160;
        end
        o_pin[2] = 1'b1;
        o_pin[1] = 1'b1;
    endtask

    task automatic key(input int k, input int t);
        o_pin[k] = 1'b0;
        #(t * TK);
        o_pin[k] = 1'b1;
    endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the voice playback control block
`timescale 1ns/10ps
module tb;
    logic        i_clk          = 1'b0;
    logic        i_srst         = 1'b1;
    logic [1:0]  i_iface_mode   = 2'h1;
    logic [14:0] i_key_mode;
    logic [7:0]  i_seg_last;
    logic        i_player_ready;
    logic        i_seg_done     = 1'b0;
    logic        stall          = 1'b0;
    logic [31:0] rq             = 32'h0000_617f;
    wire  [4:0]  pins;
    wire         o_play_start;
    wire         o_stop;
    wire         o_paused;
    wire         o_loop;
    wire         o_busy;
    wire         o_sleep_ok;
    wire  [7:0]  o_play_seg;
    wire  [2:0]  o_volume;
    logic [8:0]  exp_q[$];
    logic [31:0] rnd            = 32'h0000_617f;
    logic [7:0]  b;
    int          kp[8]          = '{2, 2, 2, 4, 1, 3, 0, 0};
    logic [7:0]  sg             = 8'h02;
    logic        bsy            = 1'b0;
    int          bad_count      = 0;
    int          compares       = 0;

    always #20 i_clk = ~i_clk;

    vpc_host host_u (.o_pin(pins));

    vpc_ctrl #(.TICK_CYC(2), .DEB_TK(10), .ST_TK(40), .BIT_TK(20), .FIFO_D(4)) dut_u (
        .i_clk(i_clk), .i_srst(i_srst), .i_port_pin(pins), .i_iface_mode(i_iface_mode),
        .i_key_mode(i_key_mode), .i_seg_last(i_seg_last), .i_player_ready(i_player_ready),
        .i_seg_done(i_seg_done), .o_play_start(o_play_start), .o_play_seg(o_play_seg),
        .o_stop(o_stop), .o_paused(o_paused), .o_loop(o_loop), .o_volume(o_volume),
        .o_busy(o_busy), .o_sleep_ok(o_sleep_ok)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // random player stalls unless a scenario holds the player off
    always @(negedge i_clk) begin
        rq = xs(rq);
        i_player_ready <= !stall && (rq[1:0] != 2'b00);
    end

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge i_clk);
        chk("pending", 9'h000, 9'(exp_q.size()));
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // stop events carry no segment
    always @(negedge i_clk) begin
        if (!i_srst && (o_play_start === 1'b1 || o_stop === 1'b1)) begin
            if (exp_q.size() == 0)
                chk("event", 9'h1ff, {o_stop, o_play_seg});
            else
                chk("event", exp_q.pop_front(), {o_stop, o_stop ? 8'h00 : o_play_seg});
        end
    end

    initial begin
        repeat (30000) @(posedge i_clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        i_key_mode = rnd[14:0];
        i_seg_last = 8'(2 + rnd % 6);
        repeat (6) @(negedge i_clk);
        i_srst = 1'b0;
        @(negedge i_clk);
        chk("volume", 9'h007, {6'h00, o_volume});
        repeat (60) @(negedge i_clk);
        rnd = xs(rnd);
        b = 8'(rnd % 220);
        exp_q.push_back({1'b0, b});
        host_u.ow_byte(b);
        settle(20);
        chk("busy", 9'h001, {8'h00, o_busy});
        chk("sleep", 9'h000, {8'h00, o_sleep_ok});
        for (int v = 0; v < 8; v++) begin
            host_u.ow_byte(8'he0 + 8'(v));
            settle(20);
            chk("volume", 9'(v), {6'h00, o_volume});
        end
        host_u.ow_byte(8'hf2);
        settle(20);
        chk("loop", 9'h001, {8'h00, o_loop});
        exp_q.push_back({1'b0, b});
        i_seg_done = ~i_seg_done;
        @(negedge i_clk);
        i_seg_done = ~i_seg_done;
        host_u.ow_byte(8'he8);
        settle(20);
        exp_q.push_back(9'h100);
        host_u.ow_byte(8'hfe);
        settle(20);
        // stalled player: four in the fifo, the held fifth overwritten by the sixth
        stall = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            b = 8'(rnd % 220);
            if (i != 4)
                exp_q.push_back({1'b0, b});
            host_u.ow_byte(b);
            repeat (4) @(negedge i_clk);
        end
        stall = 1'b0;
        settle(30);
        i_seg_done = ~i_seg_done;
        @(negedge i_clk);
        i_seg_done = ~i_seg_done;
        settle(2);
        chk("busy", 9'h000, {8'h00, o_busy});
        exp_q.push_back(9'h100);
        host_u.ow_byte(8'hfe);
        settle(20);
        i_iface_mode = i_iface_mode + 2'h1;
        i_key_mode = rnd[14:0];
        exp_q.push_back(9'h002);
        host_u.tw_byte(8'h02);
        settle(20);
        chk("busy", 9'h001, {8'h00, o_busy});
        host_u.key(0, 30);
        settle(40);
        exp_q.push_back(9'h100);
        host_u.tw_byte(8'hfe);
        settle(20);
        // key mode, either code that selects it
        i_iface_mode = {2{rnd[0]}};
        i_key_mode = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
        for (int i = 0; i < 8; i++) begin
            if (kp[i] == 0)
                exp_q.push_back(bsy ? 9'h100 : {1'b0, sg});
            else if (kp[i] == 1 || kp[i] == 3)
                sg = (sg < i_seg_last) ? sg + 8'h01 : (kp[i] == 3 ? 8'h00 : sg);
            else
                sg = (sg != 8'h00) ? sg - 8'h01 : (kp[i] == 4 ? i_seg_last : sg);
            if (kp[i] != 0)
                exp_q.push_back({1'b0, sg});
            bsy = (kp[i] != 0) || !bsy;
            host_u.key(kp[i], 30);
            settle(30);
        end
        i_key_mode = {rnd[8:0], 3'h7, 3'h6};
        host_u.key(0, 30);
        settle(30);
        chk("paused", 9'h001, {8'h00, o_paused});
        chk("busy", 9'h001, {8'h00, o_busy});
        host_u.key(0, 30);
        settle(30);
        chk("paused", 9'h000, {8'h00, o_paused});
        host_u.key(1, 4);
        settle(30);
        exp_q.push_back(9'h100);
        host_u.key(1, 30);
        settle(30);
        host_u.key(1, 30);
        settle(30);
        chk("busy", 9'h000, {8'h00, o_busy});
        chk("sleep", 9'h001, {8'h00, o_sleep_ok});
        tally_and_finish();
    end
endmodule
